// file: rtl/tmcc_pkg.sv
/*
  Shared constants and types for the timer modulo and channel control
  block: register offsets, field positions, reset values, channel modes
  and the Wishbone request and response carriers.
  Assumes a 32-bit classic Wishbone bus with byte addresses.
*/
package tmcc_pkg;

  // Bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_STATUS_CONTROL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_COUNTER = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_MODULO_HIGH = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_MODULO_LOW = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_CHANNEL_SC = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_CHANNEL_VALUE = 8'h14;

  // Timer status/control field positions
  localparam int TSC_OVF_BIT = 7;
  localparam int TSC_OVIE_BIT = 6;
  localparam int TSC_CPWM_BIT = 5;
  localparam int TSC_CLKS_LSB = 3;
  localparam int TSC_PS_LSB = 0;

  // Channel status/control field positions
  localparam int CSC_FLAG_BIT = 7;
  localparam int CSC_IE_BIT = 6;
  localparam int CSC_MODE_B_BIT = 5;
  localparam int CSC_MODE_A_BIT = 4;
  localparam int CSC_ELS_LSB = 2;

  // Reset values and counter landmarks
  localparam logic [7:0] TSC_RESET = 8'h00;
  localparam logic [7:0] CSC_RESET = 8'h00;
  localparam logic [15:0] MODULO_RESET = 16'h0000;
  localparam logic [15:0] COUNT_ZERO = 16'h0000;
  localparam logic [15:0] COUNT_FULL = 16'hffff;
  localparam logic [15:0] COUNT_FULL_M1 = 16'hfffe;
  localparam logic [15:0] CHV_RESET = 16'h0000;

  // Field encodings
  localparam logic [1:0] CLKS_OFF = 2'b00;
  localparam logic [1:0] ELS_RELEASE = 2'b00;
  localparam logic [1:0] ELS_RISE = 2'b01;
  localparam logic [1:0] ELS_FALL = 2'b10;
  localparam logic [1:0] ELS_BOTH = 2'b11;

  // Channel operating modes
  typedef enum logic [1:0] {
    TMCC_CAPTURE,
    TMCC_COMPARE,
    TMCC_EPWM,
    TMCC_CPWM
  } tmcc_mode_e;

  // Wishbone request from the master
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [ADDR_W-1:0] adr;
    logic [3:0] sel;
    logic [DATA_W-1:0] dat;
  } tmcc_wb_req_s;

  // Wishbone answer to the master
  typedef struct packed {
    logic ack;
    logic [DATA_W-1:0] dat;
  } tmcc_wb_rsp_s;

endpackage

// file: rtl/tmcc_timer.sv
/*
  Timer core with buffered modulo, up or up/down counter, overflow flag
  and one capture/compare/PWM channel behind a classic Wishbone slave.
  Assumes a prescaled count_tick pulse on core_clk and a debug freeze
  level from logic on the same clock; the channel pin is asynchronous.
*/
// Summary of operation
// (RULE1) At the modulo value the counter returns to zero and sets overflow.
// (RULE2) One modulo byte written alone holds off the overflow flag.
// (RULE3) Reset clears modulo to zero; zero means free-running full range.
// (RULE4) Modulo bytes go to a buffer; stopped counter loads on second byte.
// (RULE5) Running counter loads buffer when stepping to modulo, or to 0xFFFF.
// (RULE6) Any status/control write restarts the modulo byte sequence.
// (RULE7) In debug the byte sequence freezes and modulo writes go direct.
// (RULE8) Software should clear the counter before writing a new modulo.
// (RULE9) Input capture sets the channel flag on the chosen pin edge.
// (RULE10) Compare and PWM modes set the channel flag on counter match.
// (RULE11) PWM at 0% or 100% duty never sets the channel flag.
// (RULE12) Channel interrupt is the flag gated by its enable bit.
// (RULE13) Flag clears by read-seen-set then write zero; new events win.
// (RULE14) Reset clears channel flag and interrupt enable.
// (RULE15) Channel register: flag 7, enable 6, mode B 5, mode A 4, edge 3:2.
// (RULE16) Edge select 00 releases the pin; compare still sets the flag.
// (RULE17) Mode 00 captures: 01 rising, 10 falling, 11 both edges.
// (RULE18) Mode 01 compares: 00 none, 01 toggle, 10 clear, 11 set.
// (RULE19) Mode 1X is edge PWM: 10 high-true clear, X1 low-true set.
// (RULE20) Center select gives center PWM on match while counting up.
// (RULE21) Pin edges come from synchronised registered history.
// (RULE22) Clock source 00 stops the counter; other values let it run.
// (RULE23) Center select makes the counter count up and down.
// (RULE24) Center PWM takes the opposite action on matches counting down.
`timescale 1ns/1ps

module tmcc_timer (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire tmcc_pkg::tmcc_wb_req_s wb_req,
  output tmcc_pkg::tmcc_wb_rsp_s wb_rsp,
  input wire logic count_tick,
  input wire logic background_debug_mode,
  input wire logic channel_pin_in,
  output logic channel_pin_out,
  output logic channel_pin_oe_n,
  output logic [1:0] clock_source_select,
  output logic [2:0] prescale_select,
  output logic center_pwm_select,
  output logic overflow_flag,
  output logic [15:0] counter_value,
  output logic overflow_irq,
  output logic channel_irq
);
  import tmcc_pkg::*;

  // Mode decode from center select and mode bits
  function automatic tmcc_mode_e decode_mode(input logic cpwm,
                                             input logic mode_b,
                                             input logic mode_a);
    if (cpwm) begin
      decode_mode = TMCC_CPWM;
    end else if (mode_b) begin
      decode_mode = TMCC_EPWM;
    end else if (mode_a) begin
      decode_mode = TMCC_COMPARE;
    end else begin
      decode_mode = TMCC_CAPTURE;
    end
  endfunction

  // Register state
  logic overflow_ie;
  logic overflow_armed;
  logic [15:0] modulo;
  logic [15:0] modulo_buf;
  logic mod_high_seen;
  logic mod_low_seen;
  logic mod_load_pending;
  logic count_down;
  logic channel_event_flag;
  logic channel_irq_enable;
  logic channel_mode_b;
  logic channel_mode_a;
  logic [1:0] edge_level_select;
  logic channel_armed;
  logic [15:0] channel_value;
  logic pin_sync1;
  logic pin_sync2;
  logic pin_prev;
  logic ack;
  logic [DATA_W-1:0] read_data;

  // Combinational terms
  logic bus_take;
  logic wr;
  logic rd;
  logic wr_lane0;
  logic wr_tsc;
  logic wr_cnt;
  logic wr_modh;
  logic wr_modl;
  logic wr_csc;
  logic wr_chv;
  logic cnt_step;
  logic [15:0] top;
  logic [15:0] next_cnt;
  logic next_down;
  logic ovf_cond;
  logic wrap_up;
  logic mod_partial;
  logic mod_load_due;
  logic ovf_set;
  tmcc_mode_e mode;
  logic is_pwm;
  logic duty_zero;
  logic duty_full;
  logic duty_extreme;
  logic ch_match;
  logic up_match;
  logic edge_hit;
  logic capture_evt;
  logic ch_set;
  logic high_true;
  logic [DATA_W-1:0] next_read;

  // Bus decode; writes and read effects happen on the ack edge
  assign bus_take = wb_req.cyc & wb_req.stb & ack;
  assign wr = bus_take & wb_req.we;
  assign rd = bus_take & ~wb_req.we;
  assign wr_lane0 = wr & wb_req.sel[0];
  assign wr_tsc = wr_lane0 & (wb_req.adr == OFS_STATUS_CONTROL);
  assign wr_cnt = wr & (wb_req.adr == OFS_COUNTER);
  assign wr_modh = wr_lane0 & (wb_req.adr == OFS_MODULO_HIGH);
  assign wr_modl = wr_lane0 & (wb_req.adr == OFS_MODULO_LOW);
  assign wr_csc = wr_lane0 & (wb_req.adr == OFS_CHANNEL_SC);
  assign wr_chv = wr & (wb_req.adr == OFS_CHANNEL_VALUE);

  // Counter runs only with a clock source and outside debug
  assign cnt_step = count_tick & (clock_source_select != CLKS_OFF) // RULE22
                    & ~background_debug_mode;
  assign top = (modulo == MODULO_RESET) ? COUNT_FULL : modulo; // RULE3

  // Next count, direction and overflow condition
  always_comb begin
    next_cnt = counter_value + 16'h0001;
    next_down = count_down;
    ovf_cond = 1'b0;
    wrap_up = 1'b0;
    if (!center_pwm_select) begin
      next_down = 1'b0;
      if (counter_value == top || counter_value == COUNT_FULL) begin
        next_cnt = COUNT_ZERO; // RULE1
        ovf_cond = 1'b1;
        wrap_up = 1'b1;
      end
    end else if (!count_down) begin
      if (counter_value >= top) begin
        next_cnt = counter_value - 16'h0001; // RULE23
        next_down = 1'b1;
        ovf_cond = 1'b1;
      end
    end else if (counter_value == COUNT_ZERO) begin
      next_down = 1'b0;
    end else begin
      next_cnt = counter_value - 16'h0001;
    end
  end

  // Main counter; any write to it clears it
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      counter_value <= COUNT_ZERO;
      count_down <= 1'b0;
    end else if (wr_cnt) begin
      counter_value <= COUNT_ZERO;
      count_down <= 1'b0;
    end else if (cnt_step) begin
      counter_value <= next_cnt;
      count_down <= next_down;
    end
  end

  // Overflow held off while only one modulo byte is in
  assign mod_partial = mod_high_seen ^ mod_low_seen; // RULE2
  assign ovf_set = cnt_step & ovf_cond & ~mod_partial; // RULE2
  assign mod_load_due = mod_load_pending & cnt_step & ~next_down // RULE5
    & ((modulo == MODULO_RESET) ? (counter_value == COUNT_FULL_M1)
       : (counter_value == modulo - 16'h0001));

  // Timer status/control fields
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      overflow_ie <= TSC_RESET[TSC_OVIE_BIT];
      center_pwm_select <= TSC_RESET[TSC_CPWM_BIT];
      clock_source_select <= TSC_RESET[TSC_CLKS_LSB +: 2];
      prescale_select <= TSC_RESET[TSC_PS_LSB +: 3];
    end else if (wr_tsc) begin
      overflow_ie <= wb_req.dat[TSC_OVIE_BIT];
      center_pwm_select <= wb_req.dat[TSC_CPWM_BIT];
      clock_source_select <= wb_req.dat[TSC_CLKS_LSB +: 2];
      prescale_select <= wb_req.dat[TSC_PS_LSB +: 3];
    end
  end

  // Overflow flag with read-then-write-zero clear; a set wins
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      overflow_flag <= TSC_RESET[TSC_OVF_BIT];
      overflow_armed <= 1'b0;
    end else if (ovf_set) begin
      overflow_flag <= 1'b1; // RULE1
      overflow_armed <= 1'b0;
    end else if (wr_tsc && overflow_armed && !wb_req.dat[TSC_OVF_BIT]) begin
      overflow_flag <= 1'b0;
      overflow_armed <= 1'b0;
    end else if (rd && wb_req.adr == OFS_STATUS_CONTROL &&
                 read_data[TSC_OVF_BIT]) begin
      overflow_armed <= 1'b1;
    end
  end

  // Modulo byte buffer, byte sequence and active modulo
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      modulo <= MODULO_RESET; // RULE3
      modulo_buf <= MODULO_RESET;
      mod_high_seen <= 1'b0;
      mod_low_seen <= 1'b0;
      mod_load_pending <= 1'b0;
    end else if (wr_tsc) begin
      mod_high_seen <= 1'b0; // RULE6
      mod_low_seen <= 1'b0;
      mod_load_pending <= 1'b0;
    end else if (background_debug_mode) begin
      if (wr_modh) begin
        modulo[15:8] <= wb_req.dat[7:0]; // RULE7
      end
      if (wr_modl) begin
        modulo[7:0] <= wb_req.dat[7:0]; // RULE7
      end
    end else if (wr_modh || wr_modl) begin
      if (wr_modh) begin
        modulo_buf[15:8] <= wb_req.dat[7:0]; // RULE4
      end else begin
        modulo_buf[7:0] <= wb_req.dat[7:0]; // RULE4
      end
      if ((wr_modh && mod_low_seen) || (wr_modl && mod_high_seen)) begin
        mod_high_seen <= 1'b0;
        mod_low_seen <= 1'b0;
        if (clock_source_select == CLKS_OFF) begin
          modulo <= wr_modh ? {wb_req.dat[7:0], modulo_buf[7:0]}
                            : {modulo_buf[15:8], wb_req.dat[7:0]}; // RULE4
          mod_load_pending <= 1'b0;
        end else begin
          mod_load_pending <= 1'b1; // RULE5
        end
      end else begin
        mod_high_seen <= mod_high_seen | wr_modh;
        mod_low_seen <= mod_low_seen | wr_modl;
      end
    end else if (mod_load_due) begin
      modulo <= modulo_buf; // RULE5
      mod_load_pending <= 1'b0;
    end else if (mod_load_pending && clock_source_select == CLKS_OFF) begin
      modulo <= modulo_buf; // RULE4
      mod_load_pending <= 1'b0;
    end
  end

  // Channel mode and duty extremes
  assign mode = decode_mode(center_pwm_select, channel_mode_b,
                            channel_mode_a);
  assign is_pwm = (mode == TMCC_EPWM) || (mode == TMCC_CPWM);
  assign duty_zero = (channel_value == COUNT_ZERO);
  assign duty_full = (mode == TMCC_CPWM) ? (channel_value >= top)
                                         : (channel_value > top);
  assign duty_extreme = is_pwm & (duty_zero | duty_full);
  assign high_true = (edge_level_select == ELS_FALL);

  // Match on the step into the channel value
  assign ch_match = cnt_step & (next_cnt == channel_value) // RULE10
                    & (mode != TMCC_CAPTURE);
  assign up_match = ch_match & ~next_down;

  // Pin synchroniser and registered history
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      pin_sync1 <= 1'b0;
      pin_sync2 <= 1'b0;
      pin_prev <= 1'b0;
    end else begin
      pin_sync1 <= channel_pin_in;
      pin_sync2 <= pin_sync1;
      pin_prev <= pin_sync2; // RULE21
    end
  end

  // Edge selection for capture
  always_comb begin
    unique case (edge_level_select)
      ELS_RISE: edge_hit = pin_sync2 & ~pin_prev; // RULE17
      ELS_FALL: edge_hit = ~pin_sync2 & pin_prev; // RULE17
      ELS_BOTH: edge_hit = pin_sync2 ^ pin_prev; // RULE17
      ELS_RELEASE: edge_hit = 1'b0;
    endcase
  end
  assign capture_evt = (mode == TMCC_CAPTURE) & edge_hit; // RULE9
  assign ch_set = capture_evt | (ch_match & ~duty_extreme); // RULE11

  // Channel control bits
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      channel_irq_enable <= CSC_RESET[CSC_IE_BIT]; // RULE14
      channel_mode_b <= CSC_RESET[CSC_MODE_B_BIT];
      channel_mode_a <= CSC_RESET[CSC_MODE_A_BIT];
      edge_level_select <= CSC_RESET[CSC_ELS_LSB +: 2];
    end else if (wr_csc) begin
      channel_irq_enable <= wb_req.dat[CSC_IE_BIT]; // RULE15
      channel_mode_b <= wb_req.dat[CSC_MODE_B_BIT];
      channel_mode_a <= wb_req.dat[CSC_MODE_A_BIT];
      edge_level_select <= wb_req.dat[CSC_ELS_LSB +: 2];
    end
  end

  // Channel flag with read-then-write-zero clear; a new event wins
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      channel_event_flag <= CSC_RESET[CSC_FLAG_BIT]; // RULE14
      channel_armed <= 1'b0;
    end else if (ch_set) begin
      channel_event_flag <= 1'b1; // RULE13
      channel_armed <= 1'b0;
    end else if (wr_csc && channel_armed && !wb_req.dat[CSC_FLAG_BIT]) begin
      channel_event_flag <= 1'b0; // RULE13
      channel_armed <= 1'b0;
    end else if (rd && wb_req.adr == OFS_CHANNEL_SC &&
                 read_data[CSC_FLAG_BIT]) begin
      channel_armed <= 1'b1; // RULE13
    end
  end

  // Channel value: capture store, or direct write outside capture
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      channel_value <= CHV_RESET;
    end else if (capture_evt) begin
      channel_value <= counter_value; // RULE9
    end else if (wr_chv && mode != TMCC_CAPTURE) begin
      if (wb_req.sel[1]) begin
        channel_value[15:8] <= wb_req.dat[15:8];
      end
      if (wb_req.sel[0]) begin
        channel_value[7:0] <= wb_req.dat[7:0];
      end
    end
  end

  // Channel output level
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      channel_pin_out <= 1'b0;
    end else if (mode == TMCC_COMPARE) begin
      if (ch_match) begin
        unique case (edge_level_select)
          ELS_RISE: channel_pin_out <= ~channel_pin_out; // RULE18
          ELS_FALL: channel_pin_out <= 1'b0; // RULE18
          ELS_BOTH: channel_pin_out <= 1'b1; // RULE18
          ELS_RELEASE: channel_pin_out <= channel_pin_out; // RULE16
        endcase
      end
    end else if (is_pwm) begin
      if (duty_extreme) begin
        channel_pin_out <= duty_zero ? ~high_true : high_true; // RULE11
      end else if (up_match) begin
        channel_pin_out <= ~high_true; // RULE19 RULE20
      end else if (ch_match) begin
        channel_pin_out <= high_true; // RULE24
      end else if (mode == TMCC_EPWM && cnt_step && wrap_up) begin
        channel_pin_out <= high_true; // RULE19
      end
    end
  end

  // Pin driven only in output modes with a nonzero edge/level field
  assign channel_pin_oe_n = (edge_level_select == ELS_RELEASE) // RULE16
                            | (mode == TMCC_CAPTURE);

  // Interrupt requests
  assign channel_irq = channel_event_flag & channel_irq_enable; // RULE12
  assign overflow_irq = overflow_flag & overflow_ie;

  // Read multiplexer; unmapped offsets read zero
  always_comb begin
    next_read = '0;
    unique case (wb_req.adr)
      OFS_STATUS_CONTROL: begin
        next_read[TSC_OVF_BIT] = overflow_flag;
        next_read[TSC_OVIE_BIT] = overflow_ie;
        next_read[TSC_CPWM_BIT] = center_pwm_select;
        next_read[TSC_CLKS_LSB +: 2] = clock_source_select;
        next_read[TSC_PS_LSB +: 3] = prescale_select;
      end
      OFS_COUNTER: next_read[15:0] = counter_value;
      OFS_MODULO_HIGH: next_read[7:0] = modulo[15:8];
      OFS_MODULO_LOW: next_read[7:0] = modulo[7:0];
      OFS_CHANNEL_SC: begin
        next_read[CSC_FLAG_BIT] = channel_event_flag; // RULE15
        next_read[CSC_IE_BIT] = channel_irq_enable;
        next_read[CSC_MODE_B_BIT] = channel_mode_b;
        next_read[CSC_MODE_A_BIT] = channel_mode_a;
        next_read[CSC_ELS_LSB +: 2] = edge_level_select;
      end
      OFS_CHANNEL_VALUE: next_read[15:0] = channel_value;
      default: next_read = '0;
    endcase
  end

  // Wishbone ack one cycle after the request, dropped the cycle after
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      ack <= 1'b0;
      read_data <= '0;
    end else begin
      ack <= wb_req.cyc & wb_req.stb & ~ack;
      if (wb_req.cyc && wb_req.stb && !ack) begin
        read_data <= next_read;
      end
    end
  end

  assign wb_rsp.ack = ack;
  assign wb_rsp.dat = read_data;

endmodule // tmcc_timer

// file: verif/tmcc_timer_asserts.sv
/*
  Port checker for the timer block: bus answers, counting and overflow.
  Assumes one clock domain and a synchronous active-low reset.
*/
`timescale 1ns/1ps

module tmcc_timer_asserts (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire tmcc_pkg::tmcc_wb_req_s wb_req,
  input wire tmcc_pkg::tmcc_wb_rsp_s wb_rsp,
  input wire logic count_tick,
  input wire logic background_debug_mode,
  input wire logic [1:0] clock_source_select,
  input wire logic center_pwm_select,
  input wire logic overflow_flag,
  input wire logic [15:0] counter_value,
  input wire logic overflow_irq,
  input wire logic channel_pin_oe_n
);
  import tmcc_pkg::*;

  logic run;
  logic cnt_wr;
  logic sc_wr;
  logic ie_seen;

  // Counting enable and register writes taken at an ack edge
  assign run = count_tick && clock_source_select != CLKS_OFF
               && !background_debug_mode;
  assign cnt_wr = wb_rsp.ack && wb_req.we && wb_req.adr == OFS_COUNTER;
  assign sc_wr = wb_rsp.ack && wb_req.we
                 && wb_req.adr == OFS_STATUS_CONTROL;

  // Overflow enable as last written over the bus
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      ie_seen <= 1'b0;
    end else if (sc_wr && wb_req.sel[0]) begin
      ie_seen <= wb_req.dat[TSC_OVIE_BIT];
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  ack_single_a: assert property (wb_rsp.ack |=> !wb_rsp.ack)
    else $error("ack held longer than one cycle");
  ack_timing_a: assert property (
    wb_req.cyc && wb_req.stb && !wb_rsp.ack |=> wb_rsp.ack)
    else $error("request not answered in one cycle");
  count_hold_a: assert property (
    !run && !cnt_wr |=> $stable(counter_value))
    else $error("counter moved without a tick");
  count_step_a: assert property (
    run && !cnt_wr && !center_pwm_select |=>
    (counter_value == $past(counter_value) + 16'h0001)
    || (counter_value == COUNT_ZERO))
    else $error("up count neither stepped nor wrapped");
  up_down_a: assert property (
    run && !cnt_wr && center_pwm_select |=>
    (counter_value == $past(counter_value) + 16'h0001)
    || (counter_value == $past(counter_value) - 16'h0001))
    else $error("center count did not move by one");
  ovf_wrap_a: assert property (
    $rose(overflow_flag) && !center_pwm_select |->
    counter_value == COUNT_ZERO && $past(run))
    else $error("overflow set away from a wrap");
  ovf_hold_a: assert property (
    overflow_flag && !sc_wr |=> overflow_flag)
    else $error("overflow flag dropped without a write");
  pin_reset_a: assert property (
    $rose(reset_n) |-> channel_pin_oe_n)
    else $error("pin driven after reset");
  irq_gate_a: assert property (
    overflow_irq == (overflow_flag && ie_seen))
    else $error("overflow interrupt without its flag");

endmodule // tmcc_timer_asserts

bind tmcc_timer tmcc_timer_asserts u_tmcc_timer_asserts (
  .core_clk(core_clk), .reset_n(reset_n), .wb_req(wb_req),
  .wb_rsp(wb_rsp), .count_tick(count_tick),
  .background_debug_mode(background_debug_mode),
  .clock_source_select(clock_source_select),
  .center_pwm_select(center_pwm_select), .overflow_flag(overflow_flag),
  .counter_value(counter_value), .overflow_irq(overflow_irq),
  .channel_pin_oe_n(channel_pin_oe_n)
);

// file: verif/tmcc_timer_tb_top.sv
/*
  Self-checking bench for the timer block: registers, modulo, channel.
  Assumes the port checker is bound in by its own file.
*/
`timescale 1ns/1ps

module tmcc_timer_tb_top;
  import tmcc_pkg::*;

  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  tmcc_wb_req_s wb_req = '0;
  tmcc_wb_rsp_s wb_rsp;
  logic count_tick = 1'b0;
  logic debug_on = 1'b0;
  logic pin = 1'b0;
  logic pin_out;
  logic oe_n;
  logic ovf;
  logic ch_irq;
  logic [15:0] cnt;
  logic [2:0] presc;
  logic ovf_irq;
  int fail_count = 0;
  int checked = 0;
  logic [31:0] exp_q[$];
  logic [31:0] seed = 32'hf03a2c98;
  logic [7:0] m;
  logic [1:0] els;

  always #2 core_clk = ~core_clk;

  tmcc_timer u_tmcc_timer (
    .core_clk(core_clk), .reset_n(reset_n), .wb_req(wb_req),
    .wb_rsp(wb_rsp), .count_tick(count_tick),
    .background_debug_mode(debug_on), .channel_pin_in(pin),
    .channel_pin_out(pin_out), .channel_pin_oe_n(oe_n),
    .clock_source_select(), .prescale_select(presc),
    .center_pwm_select(),
    .overflow_flag(ovf), .counter_value(cnt), .overflow_irq(ovf_irq),
    .channel_irq(ch_irq)
  );

  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic check_read(input logic [31:0] got, input logic [31:0] e);
    checked++;
    if (got !== e) begin
      fail_count++;
      $display("wrong value at %0t: read %h not %h", $time, got, e);
    end
  endtask

  task automatic check_port(input logic [15:0] got, input logic [15:0] e);
    checked++;
    if (got !== e) begin
      fail_count++;
      $display("wrong value at %0t: port %h not %h", $time, got, e);
    end
  endtask

  // Oldest read note against each read answer
  always @(posedge core_clk) begin
    if (wb_rsp.ack === 1'b1 && wb_req.we === 1'b0) begin
      if (exp_q.size() == 0) begin
        fail_count++;
        $display("wrong value at %0t: unexpected read", $time);
      end else begin
        check_read(wb_rsp.dat, exp_q.pop_front());
      end
    end
  end

  // Classic single cycle, held until ack is sampled
  task automatic xfer(input logic we, input logic [7:0] a,
                      input logic [31:0] d);
    @(posedge core_clk);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hf, dat: d};
    do begin
      @(posedge core_clk);
    end while (wb_rsp.ack !== 1'b1);
    wb_req.cyc <= 1'b0;
    wb_req.stb <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    xfer(1'b0, a, 32'h0);
  endtask

  task automatic step(input int n);
    repeat (n) begin
      @(posedge core_clk);
      count_tick <= 1'b1;
      @(posedge core_clk);
      count_tick <= 1'b0;
    end
    @(negedge core_clk);
  endtask

  // Pin change, then flag and interrupt seen, then flag cleared
  task automatic pin_ev(input logic lvl, input logic f);
    logic ie;
    ie = (els == ELS_BOTH);
    @(posedge core_clk);
    pin <= lvl;
    repeat (6) @(posedge core_clk);
    @(negedge core_clk);
    check_port({15'h0, ch_irq}, {15'h0, f & ie});
    rd(OFS_CHANNEL_SC, {24'h0, f, ie, 2'b00, els, 2'b00});
    wr(OFS_CHANNEL_SC, {24'h0, 1'b0, ie, 2'b00, els, 2'b00});
  endtask

  // Timeout guard
  initial begin
    repeat (20000) @(posedge core_clk);
    fail_count++;
    $display("wrong value at %0t: run timed out", $time);
    close_out;
  end

  // Main sequence
  initial begin
    repeat (8) @(posedge core_clk);
    reset_n <= 1'b1;
    @(negedge core_clk);
    check_port({15'h0, oe_n}, 16'h1);
    rd(OFS_MODULO_HIGH, 32'h0);
    rd(OFS_MODULO_LOW, 32'h0);
    rd(OFS_CHANNEL_SC, 32'h0);
    rd(8'h20, 32'h0);
    seed = xs(seed);
    m = 8'd2 + {5'd0, seed[2:0]};
    wr(OFS_MODULO_HIGH, 32'h0);
    wr(OFS_MODULO_LOW, {24'h0, m});
    rd(OFS_MODULO_LOW, {24'h0, m});
    wr(OFS_STATUS_CONTROL, 32'h08);
    step(m);
    check_port({15'h0, ovf}, 16'h0);
    step(1);
    check_port(cnt, 16'h0);
    check_port({15'h0, ovf}, 16'h1);
    rd(OFS_STATUS_CONTROL, 32'h88);
    wr(OFS_STATUS_CONTROL, 32'h08);
    wr(OFS_MODULO_LOW, {24'h0, m});
    step(m + 1);
    check_port({15'h0, ovf}, 16'h0);
    wr(OFS_STATUS_CONTROL, 32'h08);
    step(m + 1);
    check_port({15'h0, ovf}, 16'h1);
    wr(OFS_MODULO_HIGH, 32'h0);
    wr(OFS_MODULO_LOW, {24'h0, m + 8'd2});
    step(m + 1);
    check_port(cnt, {8'h0, m + 8'd1});
    step(2);
    check_port(cnt, 16'h0);
    @(posedge core_clk);
    debug_on <= 1'b1;
    wr(OFS_MODULO_LOW, 32'h05);
    rd(OFS_MODULO_LOW, 32'h05);
    @(posedge core_clk);
    debug_on <= 1'b0;
    wr(OFS_STATUS_CONTROL, 32'h0);
    wr(OFS_COUNTER, 32'h0);
    wr(OFS_MODULO_HIGH, 32'h0);
    wr(OFS_MODULO_LOW, 32'h08);
    wr(OFS_STATUS_CONTROL, 32'h28);
    step(10);
    check_port(cnt, 16'h6);
    wr(OFS_STATUS_CONTROL, 32'h0);
    for (int i = 1; i < 4; i++) begin
      els = 2'(i);
      wr(OFS_CHANNEL_SC, {24'h0, 1'b0, els == ELS_BOTH, 2'b00, els, 2'b00});
      pin_ev(1'b1, els[0]);
      pin_ev(1'b0, els[1]);
    end
    wr(OFS_STATUS_CONTROL, 32'h08);
    for (int i = 0; i < 4; i++) begin
      els = 2'(i == 0 ? 0 : 4 - i);
      wr(OFS_CHANNEL_SC, {24'h0, 4'b0001, els, 2'b00});
      wr(OFS_CHANNEL_VALUE, 32'h3);
      wr(OFS_COUNTER, 32'h0);
      step(3);
      if (i == 0) begin
        check_port({15'h0, oe_n}, 16'h1);
        rd(OFS_CHANNEL_SC, 32'h90);
      end else begin
        check_port({15'h0, pin_out}, {15'h0, els != ELS_FALL});
      end
    end
    wr(OFS_CHANNEL_SC, 32'h28);
    wr(OFS_COUNTER, 32'h0);
    step(3);
    check_port({15'h0, pin_out}, 16'h0);
    step(6);
    check_port({15'h0, pin_out}, 16'h1);
    // Center PWM: clear on the up match, set on the down match
    wr(OFS_STATUS_CONTROL, 32'h28);
    wr(OFS_COUNTER, 32'h0);
    step(3);
    check_port({15'h0, pin_out}, 16'h0);
    step(10);
    check_port({15'h0, pin_out}, 16'h1);
    rd(OFS_CHANNEL_SC, 32'ha8);
    wr(OFS_CHANNEL_SC, 32'h28);
    wr(OFS_CHANNEL_VALUE, 32'h0);
    wr(OFS_COUNTER, 32'h0);
    step(16);
    check_port({15'h0, pin_out}, 16'h0);
    rd(OFS_CHANNEL_SC, 32'h28);
    // Overflow interrupt enable and prescale field
    seed = xs(seed);
    m = {5'd0, seed[2:0]};
    wr(OFS_STATUS_CONTROL, {24'h0, 8'h48 | m});
    @(negedge core_clk);
    check_port({15'h0, ovf_irq}, 16'h1);
    check_port({13'h0, presc}, {8'h0, m});
    rd(OFS_STATUS_CONTROL, {24'h0, 8'hc8 | m});
    wr(OFS_STATUS_CONTROL, {24'h0, 8'h48 | m});
    @(negedge core_clk);
    check_port({15'h0, ovf_irq}, 16'h0);
    close_out;
  end

endmodule // tmcc_timer_tb_top
